// *** rtl/capture_compare_array.sv ***
// Sixteen-channel capture/compare array with two reloadable time bases.
// Assumes an AXI4-Lite master and pin inputs synchronous to CLK_SYS.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
module capture_compare_array
  import capture_compare_array_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [NUM_CH-1:0] CC_PIN_IN,
  output logic [NUM_CH-1:0] CC_PIN_OUT,
  output logic [NUM_CH-1:0] CC_PIN_OE_B,
  input wire logic [NUM_TB-1:0] EXT_COUNT_IN,
  input wire logic OVF_TIMER_TICK,
  output logic IRQ
);

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held_q, w_held_q, awready_q, wready_q, bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [TCTRL_W-1:0] tctrl_q;
  logic [IRQ_W-1:0] stat_q, mask_q;
  logic irq_q;
  logic [PRESC_W-1:0] presc_q;
  logic [NUM_TB-1:0] ext_prev_q, cnt_new_q;
  logic [CNT_W-1:0] cnt_q [NUM_TB];
  logic [CNT_W-1:0] rel_q [NUM_TB];
  chan_cfg_s cfg_q [NUM_CH];
  logic [CNT_W-1:0] val_q [NUM_CH];
  logic pin_q [NUM_CH];
  logic oe_b_q [NUM_CH];
  logic pin_in_q [NUM_CH];
  logic done_q [NUM_CH];
  logic fired_q [NUM_CH];

  wire [NUM_TB-1:0] tick, ovf, wr_tcnt;
  wire [NUM_CH-1:0] match_w, dbl_w, cap_w;
  wire [IRQ_W-1:0] evt;
  wire [NUM_TB-1:0] ext_rise = EXT_COUNT_IN & ~ext_prev_q;

  logic wr_exec, aw_acc, w_acc, ar_acc, rd_clr;
  logic [33:0] wr_old, rd_word;
  logic [31:0] wr_val;
  chan_cfg_s cfg_wr;

  // ---------------------------------------------------------------
  // Register read decode
  // ---------------------------------------------------------------
  function automatic logic [33:0] reg_read(input logic [ADDR_W-1:0] a);
    logic [3:0] idx;
    idx = a[5:2];
    reg_read = {RESP_OKAY, 32'h00000000};
    if (a[1:0] != 2'h0) begin
      reg_read[33:32] = RESP_SLVERR;
    end else if (a[7:6] == REGION_CFG) begin
      reg_read[31:0] = {26'h0000000, cfg_q[idx]};
    end else if (a[7:6] == REGION_VAL) begin
      reg_read[31:0] = {16'h0000, val_q[idx]};
    end else if (a == REG_TCTRL) begin
      reg_read[31:0] = {23'h000000, tctrl_q};
    end else if (a == REG_TCNT[0]) begin
      reg_read[31:0] = {16'h0000, cnt_q[0]};
    end else if (a == REG_TREL[0]) begin
      reg_read[31:0] = {16'h0000, rel_q[0]};
    end else if (a == REG_TCNT[1]) begin
      reg_read[31:0] = {16'h0000, cnt_q[1]};
    end else if (a == REG_TREL[1]) begin
      reg_read[31:0] = {16'h0000, rel_q[1]};
    end else if (a == REG_ISTAT) begin
      reg_read[31:0] = {14'h0000, stat_q};
    end else if (a == REG_IMASK) begin
      reg_read[31:0] = {14'h0000, mask_q};
    end else begin
      reg_read[33:32] = RESP_SLVERR;
    end
  endfunction : reg_read

  function automatic logic [PRESC_W-1:0] tick_mask(input logic [2:0] sel, input logic stagger);
    logic [PRESC_W-1:0] m;
    m = PRESC_W'((9'h001 << sel) - 9'h001);
    if (stagger) begin
      m = m | STAGGER_MASK;
    end
    tick_mask = m;
  endfunction : tick_mask

  always_comb begin
    wr_old = reg_read(awaddr_q);
    rd_word = reg_read(S_AXI_ARADDR);
    for (int b = 0; b < 4; b++) begin
      wr_val[b*8 +: 8] = wstrb_q[b] ? wdata_q[b*8 +: 8] : wr_old[b*8 +: 8];
    end
  end

  assign cfg_wr = chan_cfg_s'(wr_val[CFG_W-1:0]);

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  // Address and data are latched separately, so either may come first
  assign aw_acc = awready_q & S_AXI_AWVALID;
  assign w_acc = wready_q & S_AXI_WVALID;
  assign wr_exec = aw_held_q & w_held_q & ~bvalid_q;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_acc) begin
        awaddr_q <= S_AXI_AWADDR;
      end
      if (w_acc) begin
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      aw_held_q <= wr_exec ? 1'b0 : (aw_held_q | aw_acc);
      w_held_q <= wr_exec ? 1'b0 : (w_held_q | w_acc);
      awready_q <= wr_exec | ~(aw_held_q | aw_acc);
      wready_q <= wr_exec | ~(w_held_q | w_acc);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_exec) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_old[33:32];
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  assign ar_acc = arready_q & S_AXI_ARVALID;
  assign rd_clr = ar_acc & (S_AXI_ARADDR == REG_ISTAT);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (ar_acc) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word[31:0];
      rresp_q <= rd_word[33:32];
    end else if (rvalid_q && S_AXI_RREADY) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Control, status and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      tctrl_q <= TCTRL_RST;
      mask_q <= IRQ_RST;
    end else if (wr_exec && awaddr_q == REG_TCTRL) begin
      tctrl_q <= wr_val[TCTRL_W-1:0];
    end else if (wr_exec && awaddr_q == REG_IMASK) begin
      mask_q <= wr_val[IRQ_W-1:0];
    end
  end

  // A read clears what it returned; an event in the same cycle survives
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      stat_q <= IRQ_RST;
    end else begin
      stat_q <= (rd_clr ? IRQ_RST : stat_q) | evt;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  a_irq_level: assert property (1'b1 |=> IRQ == $past(|(stat_q & mask_q)))
    else $error("interrupt output does not follow masked status");

  // ---------------------------------------------------------------
  // Time bases
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      presc_q <= '0;
      ext_prev_q <= '0;
      cnt_new_q <= '0;
    end else begin
      presc_q <= presc_q + PRESC_W'(1);
      ext_prev_q <= EXT_COUNT_IN;
      cnt_new_q <= tick;
    end
  end

  for (genvar t = 0; t < NUM_TB; t++) begin : g_tb
    tb_ctrl_s ctl;
    logic tick_raw;
    logic [PRESC_W-1:0] m;
    assign ctl = tb_ctrl_s'(tctrl_q[t*TB_CTRL_W +: TB_CTRL_W]);
    assign m = tick_mask(ctl.clksel, tctrl_q[TCTRL_STAGGER_BIT]);

    always_comb begin
      case (ctl.clksel)
        CLK_OVF_TIMER: tick_raw = OVF_TIMER_TICK;
        CLK_EXT: tick_raw = ext_rise[t];
        default: tick_raw = ((presc_q & m) == m);
      endcase
    end

    assign tick[t] = ctl.run & tick_raw;
    assign ovf[t] = tick[t] & (cnt_q[t] == CNT_TOP);
    assign wr_tcnt[t] = wr_exec & (awaddr_q == REG_TCNT[t]);
    assign evt[IRQ_TB_BASE + t] = ovf[t];

    always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
        cnt_q[t] <= CNT_RST;
      end else if (wr_tcnt[t]) begin
        cnt_q[t] <= wr_val[CNT_W-1:0];
      end else if (ovf[t]) begin
        cnt_q[t] <= rel_q[t];
      end else if (tick[t]) begin
        cnt_q[t] <= cnt_q[t] + CNT_W'(1);
      end
    end

    always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
        rel_q[t] <= CNT_RST;
      end else if (wr_exec && awaddr_q == REG_TREL[t]) begin
        rel_q[t] <= wr_val[CNT_W-1:0];
      end
    end

    a_reload_on_ovf: assert property (ovf[t] && !wr_tcnt[t] |=> cnt_q[t] == $past(rel_q[t]))
      else $error("timer not reloaded on overflow");
    a_stagger_res: assert property (tick[t] && tctrl_q[TCTRL_STAGGER_BIT] && ctl.clksel <= CLK_DIV_MAX
      |-> presc_q[2:0] == STAGGER_MASK[2:0])
      else $error("staggered tick off the eight-cycle grid");
    a_ovf_clock: assert property (ctl.run && ctl.clksel == CLK_OVF_TIMER && !wr_tcnt[t]
      |=> cnt_q[t] != $past(cnt_q[t]) || !$past(OVF_TIMER_TICK) || $past(ovf[t] && rel_q[t] == CNT_TOP))
      else $error("overflow-timer clock did not advance timer");
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    chan_cfg_s cfg;
    logic [CNT_W-1:0] cnt_sel;
    logic rise, fall, toggle, wr_cfg, wr_valr;
    assign cfg = cfg_q[c];
    assign cnt_sel = cnt_q[cfg.tsel];
    assign rise = CC_PIN_IN[c] & ~pin_in_q[c];
    assign fall = ~CC_PIN_IN[c] & pin_in_q[c];
    assign wr_cfg = wr_exec & (awaddr_q[7:6] == REGION_CFG) & (awaddr_q[5:2] == 4'(c)) & (awaddr_q[1:0] == 2'h0);
    assign wr_valr = wr_exec & (awaddr_q[7:6] == REGION_VAL) & (awaddr_q[5:2] == 4'(c)) & (awaddr_q[1:0] == 2'h0);
    assign dbl_w[c] = cfg.dbl;
    assign cap_w[c] = cap_hit(cfg.mode, rise, fall);
    // compare on each new count, gated by once-per-period and single event
    assign match_w[c] = is_cmp(cfg.mode) & cnt_new_q[cfg.tsel] & (val_q[c] == cnt_sel)
      & ~(cfg.single & fired_q[c]) & ~(is_once(cfg.mode) & done_q[c]);
    assign evt[c] = cap_w[c] | match_w[c];

    // paired registers share the lower pin
    if (c < HALF_CH) begin : g_lo
      assign toggle = ((cfg.mode == CMP_M1) & match_w[c]) | (cfg.dbl & (match_w[c] | match_w[c + HALF_CH]));
      a_dbl_pair: assert property (cfg.dbl && match_w[c + HALF_CH] && cfg.mode != CMP_M3
        |=> pin_q[c] != $past(pin_q[c]))
        else $error("paired match did not toggle shared pin");
    end else begin : g_hi
      assign toggle = (cfg.mode == CMP_M1) & match_w[c] & ~dbl_w[c - HALF_CH];
    end

    always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
        cfg_q[c] <= CFG_RST;
      end else if (wr_cfg) begin
        cfg_q[c] <= cfg_wr;
      end
    end

    // capture wins over a software write
    always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
        val_q[c] <= CNT_RST;
      end else if (cap_w[c]) begin
        val_q[c] <= cnt_sel;
      end else if (wr_valr) begin
        val_q[c] <= wr_val[CNT_W-1:0];
      end
    end

    always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
        pin_in_q[c] <= 1'b0;
      end else begin
        pin_in_q[c] <= CC_PIN_IN[c];
      end
    end

    // one action per period, freed on overflow
    always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
        done_q[c] <= 1'b0;
      end else if (ovf[cfg.tsel]) begin
        done_q[c] <= 1'b0;
      end else if (match_w[c]) begin
        done_q[c] <= 1'b1;
      end
    end

    // re-armed only by writing the option again
    always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
        fired_q[c] <= 1'b0;
      end else if (match_w[c] && cfg.single) begin
        fired_q[c] <= 1'b1;
      end else if (wr_cfg && cfg_wr.single) begin
        fired_q[c] <= 1'b0;
      end
    end

    always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
        pin_q[c] <= 1'b0;
      end else if (cfg.mode == CMP_M3) begin
        // set on match, clear on overflow
        if (match_w[c]) begin
          pin_q[c] <= 1'b1;
        end else if (ovf[cfg.tsel]) begin
          pin_q[c] <= 1'b0;
        end
      end else if (toggle) begin
        pin_q[c] <= ~pin_q[c];
      end
    end

    // pin driven only by pin-affecting compare modes
    always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
        oe_b_q[c] <= 1'b1;
      end else begin
        oe_b_q[c] <= ~((cfg.mode == CMP_M1) | (cfg.mode == CMP_M3) | ((c < HALF_CH) & cfg.dbl));
      end
    end

    assign CC_PIN_OUT[c] = pin_q[c];
    assign CC_PIN_OE_B[c] = oe_b_q[c];

    a_cap_copy: assert property (cap_w[c] |=> val_q[c] == $past(cnt_sel))
      else $error("capture did not copy timer count");
    a_cap_irq: assert property (cap_w[c] |=> stat_q[c])
      else $error("capture did not raise channel interrupt");
    a_m0_irq: assert property (match_w[c] && cfg.mode == CMP_M0 |=> stat_q[c])
      else $error("mode 0 match raised no interrupt");
    a_m1_toggle: assert property (cfg.mode == CMP_M1 && match_w[c] && !cfg.dbl
      && !(c >= HALF_CH && dbl_w[c % HALF_CH]) |=> pin_q[c] == !$past(pin_q[c]))
      else $error("mode 1 match did not toggle pin");
    a_m2_once: assert property (cfg.mode == CMP_M2 && match_w[c] && !ovf[cfg.tsel] && !wr_cfg |=> !match_w[c])
      else $error("mode 2 matched twice in one period");
    a_m3_level: assert property (cfg.mode == CMP_M3 && match_w[c] |=> pin_q[c])
      else $error("mode 3 match did not set pin");
    a_single_block: assert property (match_w[c] && cfg.single && !wr_cfg |=> fired_q[c] && !match_w[c])
      else $error("single event not blocked after firing");
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign IRQ = irq_q;

endmodule : capture_compare_array

// *** pkg/capture_compare_array_pkg.sv ***
// Constants, register map and channel types of the capture/compare array.
// Assumes a 32-bit AXI4-Lite slave with an 8-bit byte address.
package capture_compare_array_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH = 16;
  localparam int HALF_CH = 8;
  localparam int NUM_TB = 2;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int PRESC_W = 8;
  localparam int TB_CTRL_W = 4;
  localparam int TCTRL_W = 9;
  localparam int TCTRL_STAGGER_BIT = 8;
  localparam int CFG_W = 6;
  localparam int IRQ_W = NUM_CH + NUM_TB;
  localparam int IRQ_TB_BASE = NUM_CH;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_TCTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_TCNT [NUM_TB] = '{8'h04, 8'h0C};
  localparam logic [ADDR_W-1:0] REG_TREL [NUM_TB] = '{8'h08, 8'h10};
  localparam logic [ADDR_W-1:0] REG_ISTAT = 8'h14;
  localparam logic [ADDR_W-1:0] REG_IMASK = 8'h18;
  localparam logic [1:0] REGION_CFG = 2'h1;
  localparam logic [1:0] REGION_VAL = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Timer clocking
  // ---------------------------------------------------------------
  localparam logic [2:0] CLK_OVF_TIMER = 3'h6;
  localparam logic [2:0] CLK_EXT = 3'h7;
  localparam logic [2:0] CLK_DIV_MAX = 3'h5;
  // Staggered operation limits resolution to eight cycles
  localparam logic [PRESC_W-1:0] STAGGER_MASK = 8'h07;
  localparam logic [CNT_W-1:0] CNT_TOP = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [TCTRL_W-1:0] TCTRL_RST = 9'h000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 18'h00000;

  typedef enum logic [2:0] {
    CH_OFF = 3'h0, CAP_RISE = 3'h1, CAP_FALL = 3'h2, CAP_BOTH = 3'h3,
    CMP_M0 = 3'h4, CMP_M1 = 3'h5, CMP_M2 = 3'h6, CMP_M3 = 3'h7
  } chan_mode_e;

  typedef struct packed {
    logic dbl;
    logic single;
    logic tsel;
    chan_mode_e mode;
  } chan_cfg_s;

  typedef struct packed {
    logic run;
    logic [2:0] clksel;
  } tb_ctrl_s;

  localparam chan_cfg_s CFG_RST = chan_cfg_s'(6'h00);

  function automatic logic is_cmp(input chan_mode_e m);
    is_cmp = (m == CMP_M0) || (m == CMP_M1) || (m == CMP_M2) || (m == CMP_M3);
  endfunction : is_cmp

  function automatic logic is_once(input chan_mode_e m);
    is_once = (m == CMP_M2) || (m == CMP_M3);
  endfunction : is_once

  function automatic logic cap_hit(input chan_mode_e m, input logic rise, input logic fall);
    cap_hit = ((m == CAP_RISE) && rise) || ((m == CAP_FALL) && fall) || ((m == CAP_BOTH) && (rise || fall));
  endfunction : cap_hit

endpackage : capture_compare_array_pkg

// *** sim/cc_pin_model.sv ***
// Far-side model of the channel pins: one outside source per pin.
// Assumes the bench sets the source levels just after a CLK_SYS edge.
module cc_pin_model
  import capture_compare_array_pkg::*;
(
  input wire logic [NUM_CH-1:0] pin_out,
  input wire logic [NUM_CH-1:0] pin_oe_b,
  input wire logic [NUM_CH-1:0] src_lvl,
  output logic [NUM_CH-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // shared pin wire
  // The device wins where it drives; elsewhere the outside source sets the level
  assign pin_in = (pin_oe_b & src_lvl) | (~pin_oe_b & pin_out);

endmodule : cc_pin_model

// *** sim/sixteen_channel_capture_compare_tb_top.sv ***
// Self-checking bench for the capture/compare array.
// Assumes the array package and the pin model; timer 0 is stepped by its external count input.
module sixteen_channel_capture_compare_tb_top
  import capture_compare_array_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } row_s;
  localparam row_s ROWS [6] = '{
    '{8'h08, 32'h0000_1234, 32'h0000_1234, RESP_OKAY},
    '{8'h10, 32'hFFFF_5A5A, 32'h0000_5A5A, RESP_OKAY},
    '{8'h40, 32'h0000_003F, 32'h0000_003F, RESP_OKAY},
    '{8'hBC, 32'h0000_ABCD, 32'h0000_ABCD, RESP_OKAY},
    '{8'h1C, 32'h0000_0001, 32'h0000_0000, RESP_SLVERR},
    '{8'h42, 32'h0000_0001, 32'h0000_0000, RESP_SLVERR}};
  localparam logic [5:0] CFGS [9] = '{6'h05, 6'h07, 6'h04, 6'h06, 6'h01, 6'h02, 6'h03, 6'h25, 6'h14};

  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, ovf;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv, cnt_a;
  logic [1:0] bresp, rresp, rr, ext;
  logic [NUM_CH-1:0] pin_in, pin_out, pin_oe_b, src;
  int fails, n_compared, cyc;

  capture_compare_array capture_compare_array_inst (
    .CLK_SYS(clk), .RST_B(rst_b),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CC_PIN_IN(pin_in), .CC_PIN_OUT(pin_out), .CC_PIN_OE_B(pin_oe_b),
    .EXT_COUNT_IN(ext), .OVF_TIMER_TICK(ovf), .IRQ(irq));

  cc_pin_model cc_pin_model_inst (.pin_out(pin_out), .pin_oe_b(pin_oe_b), .src_lvl(src), .pin_in(pin_in));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // Every bus task starts after an edge, so no signal is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        got = 1'b1;
        bready <= 1'b0;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        got = 1'b1;
        rready <= 1'b0;
      end
    end
  endtask : rd

  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rr);
  endtask : wok

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
    rd(a, rv, rr);
    check(what, rv, e);
  endtask : rchk

  task automatic pc(input logic [31:0] e);
    check("pins", {16'h0, pin_out & 16'h808F}, e);
  endtask : pc

  // One count per pulse; the wait covers edge detect, count and pin update
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      ext <= 2'h1;
      @(posedge clk);
      ext <= 2'h0;
      repeat (4) @(posedge clk);
    end
  endtask : tick

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, ovf} = 7'h00;
    {awaddr, araddr, wdata, ext, src} = '0;
    {fails, n_compared, cyc} = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d, rr);
      check("write resp", {30'h0, rr}, {30'h0, ROWS[i].r});
      rd(ROWS[i].a, rv, rr);
      check("read data", rv, ROWS[i].e);
      check("read resp", {30'h0, rr}, {30'h0, ROWS[i].r});
    end
    $display("Test register table done");
    wok(REG_TREL[0], 32'h0000_FFFE);
    wok(REG_TCNT[0], 32'h0000_FFFC);
    for (int c = 0; c < 9; c++) begin
      wok(8'h80 + 8'(4 * c), 32'h0000_FFFF);
      wok(8'h40 + 8'(4 * c), {26'h0, CFGS[c]});
    end
    wok(8'h7C, 32'h0000_0005);
    wok(8'hBC, 32'h0000_FFFD);
    check("oe_b", {16'h0, pin_oe_b}, 32'h0000_7F7C);
    wok(REG_TCTRL, 32'h0000_00EF);
    tick(1);
    pc(32'h0000_0080);
    tick(2);
    pc(32'h0000_0003);
    rchk("status", REG_ISTAT, 32'h0000_818F);
    // Revisit the match value inside one period
    wok(REG_TCNT[0], 32'h0000_FFFE);
    tick(1);
    pc(32'h0000_0082);
    rchk("status", REG_ISTAT, 32'h0000_0085);
    tick(1);
    pc(32'h0000_0080);
    rchk("count", REG_TCNT[0], 32'h0000_FFFE);
    rchk("status", REG_ISTAT, 32'h0001_0000);
    tick(1);
    pc(32'h0000_0003);
    rchk("status", REG_ISTAT, 32'h0000_008F);
    $display("Test compare modes done");
    src <= 16'h0070;
    repeat (4) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h0);
    wok(REG_IMASK, 32'h0000_0040);
    repeat (2) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h1);
    rchk("status", REG_ISTAT, 32'h0000_0050);
    repeat (2) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h0);
    tick(1);
    src <= 16'h0000;
    repeat (4) @(posedge clk);
    rchk("value4", 8'h90, 32'h0000_FFFF);
    rchk("value5", 8'h94, 32'h0000_FFFE);
    rchk("value6", 8'h98, 32'h0000_FFFE);
    rchk("status", REG_ISTAT, 32'h0001_0060);
    $display("Test capture done");
    repeat (3) begin
      @(posedge clk);
      ovf <= 1'b1;
      @(posedge clk);
      ovf <= 1'b0;
    end
    repeat (2) @(posedge clk);
    rchk("count1", REG_TCNT[1], 32'h0000_0003);
    $display("Test overflow clocking done");
    // Reads taken 64 edges apart: 64 ticks at full rate, 8 on the staggered grid
    wok(REG_TCTRL, 32'h0000_008F);
    for (int s = 0; s < 2; s++) begin
      rd(REG_TCNT[1], cnt_a, rr);
      repeat (61) @(posedge clk);
      rd(REG_TCNT[1], rv, rr);
      check("timer1 steps", rv - cnt_a, s ? 32'h0000_0008 : 32'h0000_0040);
      wok(REG_TCTRL, 32'h0000_018F);
    end
    $display("Test prescaler done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check("oe_b", {16'h0, pin_oe_b}, 32'h0000_FFFF);
    check("pins rst", {16'h0, pin_out}, 32'h0000_0000);
    check("irq rst", {31'h0, irq}, 32'h0);
    rchk("tctrl", REG_TCTRL, 32'h0000_0000);
    $display("Test reset done");
    close_out();
  end

endmodule : sixteen_channel_capture_compare_tb_top
